// [bench/pin_source.sv]
`default_nettype none
module pin_source (
  // Clock.
  input wire logic core_clk,
  // Pins toward the unit.
  output var logic [capture_pkg::NUM_CH-1:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  import capture_pkg::*;

  logic [1:0] phase_r = 2'h0;

  initial pins = '0;

  // ===========================================================================
  // Level changes, made just after a rising edge.
  task automatic set_pin(input int ch, input logic v);
    @(posedge core_clk);
    pins[ch] <= v;
  endtask : set_pin

  task automatic set_all(input logic [NUM_CH-1:0] v);
    @(posedge core_clk);
    pins <= v;
  endtask : set_all

  // ===========================================================================
  // Encoder on channels 0 and 1, Gray order so only one line moves per step.
  task automatic quad(input int n);
    logic [1:0] nx;
    repeat (n) begin
      @(posedge core_clk);
      nx = phase_r + 2'h1;
      phase_r <= nx;
      pins[1:0] <= {nx[1], ^nx};
      repeat (3) @(posedge core_clk);
    end
  endtask : quad
endmodule : pin_source
`default_nettype wire

// [bench/tb_input_counter_capture.sv]
`default_nettype none
`define CHK(got, exp) check_val(32'(got), 32'(exp))
module tb_input_counter_capture;
  timeunit 1ns;
  timeprecision 1ps;
  import capture_pkg::*;

  localparam int PSC = 2;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic [NUM_CH-1:0] irq_event;
  wire logic [NUM_CH-1:0] pins;
  int miscompares = 0;
  int samples_checked = 0;
  logic [DATA_W-1:0] rv, b, e;
  logic [NUM_CH-1:0] lv;
  int ch, n, d0;

  always #2.5 core_clk = ~core_clk;

  input_counter_capture #(.PRESCALE(PSC)) uut (
    .core_clk(core_clk), .sys_rst(sys_rst), .input_channel_pins(pins),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq_event(irq_event)
  );
  pin_source src (.core_clk(core_clk), .pins(pins));

  // ===========================================================================
  // Bus cycles and comparison.
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x);
    rd(a, rv);
    `CHK(rv, x);
  endtask : rchk

  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask : cyc

  task automatic pulse(input int c, input int k);
    repeat (k) begin
      src.set_pin(c, 1'b1);
      cyc(3);
      src.set_pin(c, 1'b0);
      cyc(3);
    end
    cyc(4);
  endtask : pulse

  task automatic irq_hits(input int c, input logic v, output int k);
    src.set_pin(c, v);
    k = 0;
    repeat (8) begin
      @(posedge core_clk);
      #1;
      if (irq_event[c] === 1'b1) k++;
    end
  endtask : irq_hits

  // Counting has stopped: two reads apart give the same count.
  task automatic held();
    logic [DATA_W-1:0] c1;
    rd(OFF_COUNT, c1);
    cyc(12);
    rchk(OFF_COUNT, c1);
  endtask : held

  // ===========================================================================
  // Expected values.
  function automatic logic [31:0] bank_exp(input logic [NUM_CH-1:0] v, input int bk);
    return (bk == 0) ? 32'(v[7:0]) : 32'(v[11:8]);
  endfunction : bank_exp

  function automatic int per_pulse(input logic [1:0] ed);
    return int'(ed[0]) + int'(ed[1]);
  endfunction : per_pulse

  function automatic logic [31:0] cnt_cfg(input int up, input logic [1:0] ue,
                                          input logic [1:0] md, input int dn,
                                          input logic [1:0] de);
    return 32'(up) | 32'(ue) << CNT_UP_EDGE | 32'(md) << CNT_MODE |
           32'(dn) << CNT_DN_CH | 32'(de) << CNT_DN_EDGE;
  endfunction : cnt_cfg

  function automatic logic [31:0] cap_cfg(input logic [1:0] md, input logic [1:0] ed);
    return 32'h98 | 32'(ed) << CAP_EDGE | 32'(md) << CAP_MODE;
  endfunction : cap_cfg

  task automatic final_report();
    $display("comparisons=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  initial begin
    #300us;
    miscompares++;
    final_report();
  end

  // ===========================================================================
  // Main sequence.
  initial begin
    void'($urandom(3416));
    cyc(3);
    sys_rst <= 1'b0;
    rchk(OFF_MATCH, 32'h0000ffff);
    rchk(OFF_COUNT, 32'h0);
    rchk(4'hf, 32'h0);
    repeat (6) begin
      lv = NUM_CH'($urandom());
      src.set_all(lv);
      cyc(4);
      rchk(OFF_BANK0, bank_exp(lv, 0));
      rchk(OFF_BANK1, bank_exp(lv, 1));
      ch = $urandom_range(11);
      wr(OFF_SINGLE, 32'(ch));
      rchk(OFF_SINGLE, 32'(lv[ch]));
    end
    for (int ed = 1; ed < 4; ed++) begin
      wr(OFF_IRQ_CFG, {12{2'(ed)}});
      ch = $urandom_range(11);
      src.set_pin(ch, 1'b0);
      cyc(6);
      irq_hits(ch, 1'b1, n);
      `CHK(n, ed & 1);
      irq_hits(ch, 1'b0, n);
      `CHK(n, ed >> 1);
    end
    src.set_all('0);
    wr(OFF_FUNC, 32'(func_counter));
    for (int ed = 1; ed < 4; ed++) begin
      wr(OFF_CNT_CFG, cnt_cfg(5, 2'(ed), continuous_up_mode, 0, EDGE_NONE));
      wr(OFF_CONTROL, 32'h1);
      rchk(OFF_COUNT, 32'h0);
      pulse(5, 3);
      rchk(OFF_COUNT, 32'(3 * per_pulse(2'(ed))));
    end
    wr(OFF_CNT_CFG, cnt_cfg(5, EDGE_RISING, up_down_mode, 6, EDGE_RISING));
    wr(OFF_CONTROL, 32'h1);
    pulse(5, 5);
    pulse(6, 2);
    rchk(OFF_COUNT, 32'h3);
    wr(OFF_MATCH, 32'h3);
    wr(OFF_MATCH_ALT, 32'h5);
    wr(OFF_CNT_CFG, cnt_cfg(5, EDGE_RISING, match_stop_mode, 0, EDGE_NONE));
    rchk(OFF_MATCH_ALT, 32'h0000ffff);
    wr(OFF_CONTROL, 32'h1);
    pulse(5, 6);
    rchk(OFF_COUNT, 32'h3);
    wr(OFF_FUNC, 32'(func_decoder));
    wr(OFF_DEC_CFG, 32'h10);
    wr(OFF_CONTROL, 32'h1);
    src.quad(8);
    cyc(5);
    rd(OFF_COUNT, rv);
    `CHK(rv == 32'h8 || rv == 32'hfff8, 1'b1);
    wr(OFF_SYNC_CFG, 32'h17);
    pulse(7, 1);
    rchk(OFF_COUNT, 32'h0);
    wr(OFF_SYNC_CFG, 32'h0);
    wr(OFF_DEC_CFG, 32'h3210);
    src.quad(3);
    pulse(2, 1);
    rchk(OFF_COUNT, 32'h0);
    wr(OFF_FUNC, 32'(func_capture));
    for (int p = 0; p < 2; p++) begin
      wr(OFF_CAP_CFG, cap_cfg(capture_free_run, EDGE_RISING) | 32'(p) << CAP_PRESCALE);
      wr(OFF_CONTROL, 32'h1);
      pulse(8, 1);
      cyc(10);
      pulse(9, 1);
      rd(OFF_BEGIN, b);
      rd(OFF_END, e);
      if (p == 0) begin
        d0 = int'(e) - int'(b);
        `CHK(d0 > 0, 1'b1);
      end else begin
        `CHK(int'(e) - int'(b) > 0 && int'(e) - int'(b) < d0, 1'b1);
      end
    end
    wr(OFF_CAP_CFG, cap_cfg(capture_free_run, EDGE_RISING) | 32'h1 << CAP_SAME);
    pulse(8, 1);
    rd(OFF_BEGIN, b);
    rd(OFF_END, e);
    `CHK(e, b);
    for (int ed = 1; ed < 3; ed++) begin
      wr(OFF_CAP_CFG, cap_cfg(capture_start_to_stop, 2'(ed)));
      wr(OFF_CONTROL, 32'h1);
      pulse(9, 1);
      pulse(8, 1);
      rchk(OFF_END, 32'h1);
      rchk(OFF_BEGIN, 32'(ed == 2));
      rchk(OFF_COUNT, 32'h1);
    end
    wr(OFF_CONTROL, 32'h1);
    cyc(5);
    pulse(8, 1);
    cyc(5);
    pulse(9, 1);
    rd(OFF_BEGIN, b);
    rd(OFF_END, e);
    `CHK(e > b, 1'b1);
    held();
    wr(OFF_CAP_CFG, cap_cfg(capture_run_to_stop, EDGE_RISING));
    wr(OFF_CONTROL, 32'h1);
    cyc(10);
    pulse(8, 1);
    rd(OFF_END, e);
    `CHK(e > 32'h9, 1'b1);
    held();
    for (int gl = 0; gl < 2; gl++) begin
      wr(OFF_CAP_CFG, cap_cfg(capture_gated_level, EDGE_NONE) | 32'(gl) << CAP_GATE_LOW);
      src.set_pin(8, gl != 0);
      cyc(4);
      wr(OFF_CONTROL, 32'h1);
      cyc(6);
      rchk(OFF_COUNT, 32'h0);
      src.set_pin(8, gl == 0);
      cyc(10);
      src.set_pin(8, gl != 0);
      cyc(6);
      rd(OFF_COUNT, rv);
      `CHK(rv > 32'h7 && rv < 32'h10, 1'b1);
      held();
    end
    final_report();
  end
endmodule : tb_input_counter_capture
`default_nettype wire

// [common/capture_pkg.sv]
`default_nettype none
package capture_pkg;

  // ===========================================================================
  // Register bus geometry and offsets.
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;
  localparam int NUM_CH = 12;
  localparam int BANK_W = 8;

  localparam logic [3:0] OFF_BANK0 = 4'h0;
  localparam logic [3:0] OFF_BANK1 = 4'h1;
  localparam logic [3:0] OFF_SINGLE = 4'h2;
  localparam logic [3:0] OFF_IRQ_CFG = 4'h3;
  localparam logic [3:0] OFF_FUNC = 4'h4;
  localparam logic [3:0] OFF_CNT_CFG = 4'h5;
  localparam logic [3:0] OFF_MATCH = 4'h6;
  localparam logic [3:0] OFF_MATCH_ALT = 4'h7;
  localparam logic [3:0] OFF_DEC_CFG = 4'h8;
  localparam logic [3:0] OFF_CAP_CFG = 4'h9;
  localparam logic [3:0] OFF_SYNC_CFG = 4'ha;
  localparam logic [3:0] OFF_CONTROL = 4'hb;
  localparam logic [3:0] OFF_COUNT = 4'hc;
  localparam logic [3:0] OFF_BEGIN = 4'hd;
  localparam logic [3:0] OFF_END = 4'he;

  // ===========================================================================
  // Field positions.
  localparam int CNT_UP_CH = 0;
  localparam int CNT_UP_EDGE = 4;
  localparam int CNT_MODE = 6;
  localparam int CNT_DN_CH = 8;
  localparam int CNT_DN_EDGE = 12;
  localparam int DEC_I_CH = 0;
  localparam int DEC_Q_CH = 4;
  localparam int DEC_IDX_CH = 8;
  localparam int DEC_IDX_EN = 12;
  localparam int DEC_IDX_POL = 13;
  localparam int CAP_PRI_CH = 0;
  localparam int CAP_SEC_CH = 4;
  localparam int CAP_SAME = 8;
  localparam int CAP_EDGE = 9;
  localparam int CAP_MODE = 11;
  localparam int CAP_PRESCALE = 13;
  localparam int CAP_GATE_LOW = 14;
  localparam int SYNC_CH = 0;
  localparam int SYNC_EDGE = 4;
  localparam int CTRL_RESET = 0;

  // ===========================================================================
  // Reset values and encodings.
  localparam logic [CNT_W-1:0] COUNT_MAX = 16'hffff;
  localparam logic [CNT_W-1:0] MATCH_RST = 16'hffff;
  localparam int PRESCALE_DIV = 8;

  // Edge selection: bit 0 rising, bit 1 falling, both set for either edge.
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISING = 2'h1;
  localparam logic [1:0] EDGE_FALLING = 2'h2;
  localparam logic [1:0] EDGE_EITHER = 2'h3;

  typedef enum logic [1:0] {
    func_plain, func_decoder, func_counter, func_capture
  } func_t;

  typedef enum logic [1:0] {
    continuous_up_mode, up_down_mode, match_stop_mode, cnt_unused
  } cnt_mode_t;

  typedef enum logic [1:0] {
    capture_free_run, capture_start_to_stop, capture_run_to_stop, capture_gated_level
  } cap_mode_t;

  typedef enum logic [1:0] {
    st_idle, st_run, st_done
  } cap_state_t;

endpackage : capture_pkg
`default_nettype wire

// [design/input_counter_capture.sv]
// The plain strobed port and the address map were decided locally.
`default_nettype none
module input_counter_capture #(
  parameter int PRESCALE = capture_pkg::PRESCALE_DIV
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic sys_rst,
  // Input channel pins.
  input wire logic [capture_pkg::NUM_CH-1:0] input_channel_pins,
  // Register port.
  input wire logic [capture_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [capture_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [capture_pkg::DATA_W-1:0] reg_rdata,
  // Per-channel edge events.
  output logic [capture_pkg::NUM_CH-1:0] irq_event
);
  import capture_pkg::*;

  localparam int PW = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;

  function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
    return (sel[0] & r) | (sel[1] & f);
  endfunction : edge_hit

  function automatic logic pick(input logic [NUM_CH-1:0] v, input logic [3:0] ch);
    return (ch < 4'(NUM_CH)) ? v[ch] : 1'b0;
  endfunction : pick

  // ===========================================================================
  // Input synchronisers and edge detection.
  logic [NUM_CH-1:0] sync1_r;
  logic [NUM_CH-1:0] sync2_r;
  logic [NUM_CH-1:0] prev_r;
  logic [NUM_CH-1:0] rise;
  logic [NUM_CH-1:0] fall;
  logic [NUM_CH-1:0] irq_event_r;
  logic [2*NUM_CH-1:0] irq_cfg_r;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r <= '0;
    end else begin
      sync1_r <= input_channel_pins;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  assign rise = sync2_r & ~prev_r;
  assign fall = ~sync2_r & prev_r;

  generate
    for (genvar i = 0; i < NUM_CH; i++) begin : g_irq
      always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          irq_event_r[i] <= 1'b0;
        end else begin
          irq_event_r[i] <= edge_hit(irq_cfg_r[2*i +: 2], rise[i], fall[i]);
        end
      end
    end
  endgenerate

  assign irq_event = irq_event_r;

  // ===========================================================================
  // Configuration registers.
  func_t func_r;
  logic [13:0] cnt_cfg_r;
  logic [CNT_W-1:0] match_r;
  logic [CNT_W-1:0] match_alt_r;
  logic [13:0] dec_cfg_r;
  logic [14:0] cap_cfg_r;
  logic [5:0] sync_cfg_r;
  logic [3:0] single_sel_r;
  logic force_rst;
  logic wr_cnt_cfg;

  assign force_rst = reg_wr && reg_addr == OFF_CONTROL && reg_wdata[CTRL_RESET];
  assign wr_cnt_cfg = reg_wr && reg_addr == OFF_CNT_CFG;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      func_r <= func_plain;
      cnt_cfg_r <= '0;
      match_r <= MATCH_RST;
      dec_cfg_r <= '0;
      cap_cfg_r <= '0;
      sync_cfg_r <= '0;
      single_sel_r <= '0;
      irq_cfg_r <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        OFF_SINGLE: single_sel_r <= reg_wdata[3:0];
        OFF_IRQ_CFG: irq_cfg_r <= reg_wdata[2*NUM_CH-1:0];
        OFF_FUNC: func_r <= func_t'(reg_wdata[1:0]);
        OFF_CNT_CFG: cnt_cfg_r <= reg_wdata[13:0];
        OFF_MATCH: match_r <= reg_wdata[CNT_W-1:0];
        OFF_DEC_CFG: dec_cfg_r <= reg_wdata[13:0];
        OFF_CAP_CFG: cap_cfg_r <= reg_wdata[14:0];
        OFF_SYNC_CFG: sync_cfg_r <= reg_wdata[5:0];
        default: ;
      endcase
    end
  end

  // Choosing match-stop mode parks the second match register at its top value.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      match_alt_r <= MATCH_RST;
    end else if (wr_cnt_cfg && reg_wdata[CNT_MODE +: 2] == 2'(match_stop_mode)) begin
      match_alt_r <= COUNT_MAX;
    end else if (reg_wr && reg_addr == OFF_MATCH_ALT) begin
      match_alt_r <= reg_wdata[CNT_W-1:0];
    end
  end

  // ===========================================================================
  // Event decode for each function.
  cnt_mode_t cnt_mode;
  cap_mode_t cap_mode;
  logic [CNT_W-1:0] count_r;
  logic sync_ev;
  logic up_ev;
  logic dn_ev;
  logic cnt_hold;
  logic qa, qb, qpa, qpb, q_chg, q_up, q_dn, idx_hit;
  logic [3:0] pri_ch;
  logic [3:0] end_ch;
  logic pri_ev;
  logic end_ev;
  logic gate_on;

  assign cnt_mode = cnt_mode_t'(cnt_cfg_r[CNT_MODE +: 2]);
  assign cap_mode = cap_mode_t'(cap_cfg_r[CAP_MODE +: 2]);
  assign sync_ev = edge_hit(sync_cfg_r[SYNC_EDGE +: 2], pick(rise, sync_cfg_r[SYNC_CH +: 4]),
    pick(fall, sync_cfg_r[SYNC_CH +: 4]));

  assign up_ev = edge_hit(cnt_cfg_r[CNT_UP_EDGE +: 2], pick(rise, cnt_cfg_r[CNT_UP_CH +: 4]),
    pick(fall, cnt_cfg_r[CNT_UP_CH +: 4]));
  assign dn_ev = cnt_mode == up_down_mode &&
    cnt_cfg_r[CNT_DN_CH +: 4] != cnt_cfg_r[CNT_UP_CH +: 4] &&
    edge_hit(cnt_cfg_r[CNT_DN_EDGE +: 2], pick(rise, cnt_cfg_r[CNT_DN_CH +: 4]),
    pick(fall, cnt_cfg_r[CNT_DN_CH +: 4]));
  assign cnt_hold = cnt_mode == match_stop_mode &&
    (count_r == match_r || count_r == match_alt_r);

  assign qa = pick(sync2_r, dec_cfg_r[DEC_I_CH +: 4]);
  assign qb = pick(sync2_r, dec_cfg_r[DEC_Q_CH +: 4]);
  assign qpa = pick(prev_r, dec_cfg_r[DEC_I_CH +: 4]);
  assign qpb = pick(prev_r, dec_cfg_r[DEC_Q_CH +: 4]);
  assign q_chg = (qa ^ qpa) ^ (qb ^ qpb);
  assign q_up = q_chg & (qa ^ qpb);
  assign q_dn = q_chg & ~(qa ^ qpb);
  assign idx_hit = dec_cfg_r[DEC_IDX_EN] && (dec_cfg_r[DEC_IDX_POL] ?
    pick(rise, dec_cfg_r[DEC_IDX_CH +: 4]) : pick(fall, dec_cfg_r[DEC_IDX_CH +: 4]));

  assign pri_ch = cap_cfg_r[CAP_PRI_CH +: 4];
  assign end_ch = cap_cfg_r[CAP_SAME] ? pri_ch : cap_cfg_r[CAP_SEC_CH +: 4];
  assign pri_ev = edge_hit(cap_cfg_r[CAP_EDGE +: 2], pick(rise, pri_ch),
    pick(fall, pri_ch));
  assign end_ev = (cap_mode == capture_run_to_stop) ? pri_ev :
    edge_hit(cap_cfg_r[CAP_EDGE +: 2], pick(rise, end_ch), pick(fall, end_ch));
  assign gate_on = pick(sync2_r, pri_ch) ^ cap_cfg_r[CAP_GATE_LOW];

  // ===========================================================================
  // Prescaler and capture sequencing.
  logic [PW-1:0] pre_cnt_r;
  logic pre_tick;
  cap_state_t cap_state_r;
  logic end_seen_r;
  logic [CNT_W-1:0] begin_r;
  logic [CNT_W-1:0] end_r;
  logic cap_run;
  logic cap_tick;
  logic early_hit;
  logic is_cap;

  assign pre_tick = pre_cnt_r == PW'(PRESCALE - 1);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_cnt_r <= '0;
    end else begin
      pre_cnt_r <= pre_tick ? '0 : pre_cnt_r + 1'b1;
    end
  end

  assign is_cap = func_r == func_capture;
  assign early_hit = is_cap && cap_mode == capture_start_to_stop &&
    cap_state_r == st_idle && pri_ev && end_seen_r;

  always_comb begin
    case (cap_mode)
      capture_free_run: cap_run = 1'b1;
      capture_start_to_stop: cap_run = cap_state_r == st_run;
      capture_run_to_stop: cap_run = cap_state_r != st_done;
      capture_gated_level: cap_run = gate_on;
      default: cap_run = 1'b0;
    endcase
  end

  assign cap_tick = cap_run && (cap_cfg_r[CAP_PRESCALE] ? pre_tick : 1'b1);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cap_state_r <= st_idle;
      end_seen_r <= 1'b0;
    end else if (force_rst || !is_cap) begin
      cap_state_r <= st_idle;
      end_seen_r <= 1'b0;
    end else begin
      case (cap_state_r)
        st_idle: begin
          if (cap_mode == capture_start_to_stop) begin
            if (early_hit) begin
              cap_state_r <= st_done;
            end else if (pri_ev) begin
              cap_state_r <= st_run;
            end else if (end_ev) begin
              end_seen_r <= 1'b1;
            end
          end else if (cap_mode == capture_run_to_stop && end_ev) begin
            cap_state_r <= st_done;
          end
        end
        st_run: begin
          if (end_ev) begin
            cap_state_r <= st_done;
          end
        end
        st_done: cap_state_r <= st_done;
        default: cap_state_r <= st_idle;
      endcase
    end
  end

  // Begin and end captures; in gated mode the gate's edges act as events.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      begin_r <= '0;
      end_r <= '0;
    end else if (early_hit) begin
      begin_r <= pick(fall, pri_ch) ? CNT_W'(1) : CNT_W'(0);
      end_r <= CNT_W'(1);
    end else if (is_cap) begin
      case (cap_mode)
        capture_gated_level: begin
          if (gate_on && !(pick(prev_r, pri_ch) ^ cap_cfg_r[CAP_GATE_LOW])) begin
            begin_r <= count_r;
          end
          if (!gate_on && (pick(prev_r, pri_ch) ^ cap_cfg_r[CAP_GATE_LOW])) begin
            end_r <= count_r;
          end
        end
        capture_run_to_stop: begin
          if (end_ev && cap_state_r != st_done) begin
            end_r <= count_r;
          end
        end
        capture_start_to_stop: begin
          if (cap_state_r == st_idle && pri_ev) begin
            begin_r <= count_r;
          end
          if (cap_state_r == st_run && end_ev) begin
            end_r <= count_r;
          end
        end
        default: begin
          if (pri_ev) begin
            begin_r <= count_r;
          end
          if (end_ev) begin
            end_r <= count_r;
          end
        end
      endcase
    end
  end

  // ===========================================================================
  // Shared count register.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_r <= '0;
    end else if (force_rst) begin
      count_r <= '0;
    end else if (sync_ev && func_r != func_plain) begin
      count_r <= '0;
    end else begin
      case (func_r)
        func_decoder: begin
          if (idx_hit) begin
            count_r <= '0;
          end else if (q_up) begin
            count_r <= count_r + 1'b1;
          end else if (q_dn) begin
            count_r <= count_r - 1'b1;
          end
        end
        func_counter: begin
          if (!cnt_hold && up_ev && !dn_ev) begin
            count_r <= count_r + 1'b1;
          end else if (!cnt_hold && dn_ev && !up_ev) begin
            count_r <= count_r - 1'b1;
          end
        end
        func_capture: begin
          if (early_hit) begin
            count_r <= CNT_W'(1);
          end else if (cap_tick) begin
            count_r <= count_r + 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  // ===========================================================================
  // Read port: data stands in the cycle after the strobe.
  logic [DATA_W-1:0] rdata_nxt;
  logic [DATA_W-1:0] rdata_r;

  always_comb begin
    rdata_nxt = '0;
    case (reg_addr)
      OFF_BANK0: rdata_nxt = DATA_W'(sync2_r[BANK_W-1:0]);
      OFF_BANK1: rdata_nxt = DATA_W'(sync2_r[NUM_CH-1:BANK_W]);
      OFF_SINGLE: rdata_nxt = DATA_W'(pick(sync2_r, single_sel_r));
      OFF_IRQ_CFG: rdata_nxt = DATA_W'(irq_cfg_r);
      OFF_FUNC: rdata_nxt = DATA_W'(func_r);
      OFF_CNT_CFG: rdata_nxt = DATA_W'(cnt_cfg_r);
      OFF_MATCH: rdata_nxt = DATA_W'(match_r);
      OFF_MATCH_ALT: rdata_nxt = DATA_W'(match_alt_r);
      OFF_DEC_CFG: rdata_nxt = DATA_W'(dec_cfg_r);
      OFF_CAP_CFG: rdata_nxt = DATA_W'(cap_cfg_r);
      OFF_SYNC_CFG: rdata_nxt = DATA_W'(sync_cfg_r);
      OFF_COUNT: rdata_nxt = DATA_W'(count_r);
      OFF_BEGIN: rdata_nxt = DATA_W'(begin_r);
      OFF_END: rdata_nxt = DATA_W'(end_r);
      default: rdata_nxt = '0;
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= reg_rd ? rdata_nxt : '0;
    end
  end

  assign reg_rdata = rdata_r;

  // ===========================================================================
  // Checks.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_bank_read: assert property (
    reg_rd && reg_addr == OFF_BANK1 |=> reg_rdata == DATA_W'($past(sync2_r[NUM_CH-1:BANK_W])))
    else $error("bank one read wrong");
  a_pin_to_level: assert property (
    $stable(input_channel_pins) [*3] |-> sync2_r == $past(input_channel_pins, 2))
    else $error("synchroniser latency wrong");
  a_irq_rise: assert property (
    rise[0] && irq_cfg_r[0] |=> irq_event[0])
    else $error("rising edge event missed");
  a_count_up: assert property (
    func_r == func_counter && cnt_mode == continuous_up_mode && up_ev && !force_rst &&
    !sync_ev && !reg_wr |=> count_r == $past(count_r) + 1'b1)
    else $error("counter did not step");
  a_force_reset: assert property (
    force_rst |=> count_r == '0)
    else $error("forced reset ignored");
  a_match_stop: assert property (
    func_r == func_counter && cnt_hold && !force_rst && !sync_ev |=> $stable(count_r))
    else $error("count passed match");
  a_match_max: assert property (
    wr_cnt_cfg && reg_wdata[CNT_MODE +: 2] == 2'(match_stop_mode) |=> match_alt_r == COUNT_MAX)
    else $error("match register not parked");
  a_gate_hold: assert property (
    is_cap && cap_mode == capture_gated_level && !gate_on && !force_rst && !sync_ev &&
    !reg_wr |=> $stable(count_r))
    else $error("gated count moved");
  a_early_end: assert property (
    early_hit && !force_rst && !sync_ev |=> count_r == CNT_W'(1) && end_r == CNT_W'(1)
    ##1 cap_state_r == st_done)
    else $error("end before begin mishandled");

  c_match_stop: cover property (func_r == func_counter && cnt_hold && up_ev);
  c_start_stop: cover property (cap_state_r == st_run ##[1:50] cap_state_r == st_done);
  c_quad_up: cover property (func_r == func_decoder && q_up);
  c_early_end: cover property (early_hit);

endmodule : input_counter_capture
`default_nettype wire
